// [hdl/samc_chan_mux.sv]
// channel address latch and decoder for the analog switch bank
// assumes address and strobe synchronous to the clock
`timescale 1ns/1ps
module samc_chan_mux #(
  parameter int CHAN_BITS = 4,
  parameter int CHANS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [CHAN_BITS-1:0] addr_i,
  input wire logic strobe_i,
  input wire logic bank_en_i,
  output logic [CHANS-1:0] sel_o,
  output logic [CHAN_BITS-1:0] chan_o
);
  import samc_pkg::*;
  logic strobe_q;
  logic [CHAN_BITS-1:0] chan;
  // ==========================================================
  // latch address on strobe rising edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_q <= 1'b0;
      chan <= '0;
    end else begin
      strobe_q <= strobe_i;
      if (strobe_i && !strobe_q) begin
        chan <= addr_i;
      end
    end
  end
  // ==========================================================
  // one-hot switch selects, all off when bank disabled
  always_comb begin
    sel_o = '0;
    if (bank_en_i) begin
      sel_o[chan] = 1'b1;
    end
  end
  assign chan_o = chan;
endmodule

// [hdl/samc_out_drv.sv]
// output data register with one drive enable shared by all pins
// assumes load pulse from the sequencer
`timescale 1ns/1ps
module samc_out_drv #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] result_i,
  input wire logic drive_en_i,
  output logic [W-1:0] data_o,
  output logic [W-1:0] oe_n_o
);
  import samc_pkg::*;
  logic [W-1:0] data;
  // ==========================================================
  // result held until next completion
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data <= '0;
    end else if (load_i) begin
      data <= result_i;
    end
  end
  assign data_o = data;
  assign oe_n_o = drive_en_i ? '0 : '1;
endmodule

// [hdl/samc_pkg.sv]
// package for the successive approximation converter control block
// assumes one clock shared by conversion logic and host interface
// Operation
// - latch four channel address bits on strobe rising edge, hold until next
// - bank enable high routes analog input N, N from address bits
// - bank enable low switches off all sixteen multiplexer inputs
// - each conversion runs exactly eight iterations, most significant bit first
// - rising trigger clears the approximation register
// - falling trigger begins the approximation sequence
// - new trigger pulse during conversion abandons it and restarts
// - done output may feed trigger input for free-running conversions
// - done output falls within zero to eight clocks after trigger rises
// - result is positive-true binary, high bit means one
// - output data register updates one clock before done rises
package samc_pkg;
  // ==========================================================
  // sizes and reset values
  localparam int SAMC_RES_BITS = 8;
  localparam int SAMC_CHAN_BITS = 4;
  localparam int SAMC_CHANS = 16;
  localparam logic [3:0] SAMC_CHAN_RST = 4'h0;
  localparam logic [7:0] SAMC_DATA_RST = 8'h00;
  localparam logic [7:0] SAMC_SAR_RST = 8'h00;
  localparam logic [2:0] SAMC_BIT_MSB = 3'h7;
  // ==========================================================
  // conversion sequencer states
  typedef enum logic [1:0] {
    SAMC_IDLE = 2'b00,
    SAMC_ARMED = 2'b01,
    SAMC_CONV = 2'b10,
    SAMC_LOAD = 2'b11
  } samc_state_e;
  // ==========================================================
  // data output bundle
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe_n;
  } samc_out_s;
endpackage

// [hdl/samc_top.sv]
// successive approximation converter control with channel multiplexer
// assumes comparator output synchronous to CLK_I, high when input at or above trial
`timescale 1ns/1ps
module samc_top #(
  parameter int RES_BITS = samc_pkg::SAMC_RES_BITS
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [samc_pkg::SAMC_CHAN_BITS-1:0] ADDR_I,
  input wire logic ADDR_STROBE_I,
  input wire logic BANK_EN_I,
  input wire logic CONVERT_TRIGGER_I,
  input wire logic COMP_I,
  input wire logic DRIVE_EN_I,
  output logic [samc_pkg::SAMC_CHANS-1:0] CHAN_SEL_O,
  output logic [samc_pkg::SAMC_CHAN_BITS-1:0] CHAN_O,
  output logic [RES_BITS-1:0] TRIAL_O,
  output logic CONV_DONE_O,
  output samc_pkg::samc_out_s DOUT_O
);
  import samc_pkg::*;
  samc_state_e state;
  logic trig_q;
  logic [RES_BITS-1:0] sar;
  logic [RES_BITS-1:0] probe;
  logic [2:0] bit_idx;
  logic done;
  logic load;
  logic load_q;
  logic trig_rise;
  logic trig_fall;
  // ==========================================================
  // trigger edge detection
  assign trig_rise = CONVERT_TRIGGER_I && !trig_q;
  assign trig_fall = !CONVERT_TRIGGER_I && trig_q;
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= CONVERT_TRIGGER_I;
    end
  end
  // ==========================================================
  // sequencer: rise arms, fall starts, any rise restarts
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= SAMC_IDLE;
    end else if (trig_rise) begin
      state <= SAMC_ARMED;
    end else begin
      case (state)
        SAMC_IDLE: begin
          state <= SAMC_IDLE;
        end
        SAMC_ARMED: begin
          if (trig_fall) begin
            state <= SAMC_CONV;
          end
        end
        SAMC_CONV: begin
          if (bit_idx == 3'h0) begin
            state <= SAMC_LOAD;
          end
        end
        SAMC_LOAD: begin
          state <= SAMC_IDLE;
        end
        default: begin
          state <= SAMC_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // approximation register, one bit decided per cycle
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sar <= SAMC_SAR_RST;
      bit_idx <= SAMC_BIT_MSB;
    end else if (trig_rise) begin
      sar <= SAMC_SAR_RST;
      bit_idx <= SAMC_BIT_MSB;
    end else if (state == SAMC_CONV) begin
      sar[bit_idx] <= COMP_I;
      bit_idx <= bit_idx - 3'h1;
    end
  end
  // trial code: decided bits plus current test bit
  always_comb begin
    probe = sar;
    if (state == SAMC_CONV) begin
      probe[bit_idx] = 1'b1;
    end
  end
  assign TRIAL_O = probe;
  // ==========================================================
  // done flag: low the cycle after trigger rises, high after load
  assign load = (state == SAMC_LOAD);
  // delayed load so data settles one clock before done rises
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      load_q <= 1'b0;
    end else begin
      load_q <= load;
    end
  end
  // a rise in the same cycle as the set wins: restart beats completion
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      done <= 1'b0;
    end else if (trig_rise) begin
      done <= 1'b0;
    end else if (load_q) begin
      done <= 1'b1;
    end
  end
  assign CONV_DONE_O = done;
  // ==========================================================
  // channel latch and output register
  samc_chan_mux #(
    .CHAN_BITS(SAMC_CHAN_BITS),
    .CHANS(SAMC_CHANS)
  ) u_mux (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .addr_i(ADDR_I),
    .strobe_i(ADDR_STROBE_I),
    .bank_en_i(BANK_EN_I),
    .sel_o(CHAN_SEL_O),
    .chan_o(CHAN_O)
  );
  samc_out_drv #(
    .W(RES_BITS)
  ) u_out (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(load),
    .result_i(sar),
    .drive_en_i(DRIVE_EN_I),
    .data_o(DOUT_O.data),
    .oe_n_o(DOUT_O.oe_n)
  );
endmodule

// [sim/samc_comp_model.sv]
// comparator stand-in for the analog side
// assumes a steady input level from the bench
`timescale 1ns/1ps
module samc_comp_model (
  input wire logic [7:0] trial_i,
  input wire logic [7:0] level_i,
  output logic comp_o
);
  // high while input at or above trial
  assign comp_o = level_i >= trial_i;
endmodule

// [sim/samc_top_assertions.sv]
// port checker for the converter control block
// assumes bound onto samc_top, one clock domain
`timescale 1ns/1ps
module samc_top_assertions (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [samc_pkg::SAMC_CHAN_BITS-1:0] ADDR_I,
  input wire logic ADDR_STROBE_I,
  input wire logic BANK_EN_I,
  input wire logic CONVERT_TRIGGER_I,
  input wire logic DRIVE_EN_I,
  input wire logic [samc_pkg::SAMC_CHANS-1:0] CHAN_SEL_O,
  input wire logic [samc_pkg::SAMC_CHAN_BITS-1:0] CHAN_O,
  input wire logic CONV_DONE_O,
  input wire samc_pkg::samc_out_s DOUT_O
);
  import samc_pkg::*;
  // ==========================================
  // port timing properties
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_latch; $rose(ADDR_STROBE_I) |=> CHAN_O == $past(ADDR_I); endproperty
  a_latch: assert property (p_latch) else $error("no latch");
  property p_hold; !$rose(ADDR_STROBE_I) |=> $stable(CHAN_O); endproperty
  a_hold: assert property (p_hold) else $error("chan moved");
  property p_sel; BANK_EN_I |-> CHAN_SEL_O == 16'h1 << CHAN_O; endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_off; !BANK_EN_I |-> CHAN_SEL_O == 16'h0; endproperty
  a_off: assert property (p_off) else $error("bank not off");
  property p_lo; $rose(CONVERT_TRIGGER_I) |-> ##[0:8] !CONV_DONE_O; endproperty
  a_lo: assert property (p_lo) else $error("done stayed high");
  property p_oe; DOUT_O.oe_n == {8{!DRIVE_EN_I}}; endproperty
  a_oe: assert property (p_oe) else $error("bad drive");
  property p_keep; $changed(DOUT_O.data) |=> $rose(CONV_DONE_O); endproperty
  a_keep: assert property (p_keep) else $error("data moved");
  property p_len; ($fell(CONVERT_TRIGGER_I) && !CONV_DONE_O)
    ##1 !CONVERT_TRIGGER_I [*8] ##1 !CONVERT_TRIGGER_I [*2]
    |=> $rose(CONV_DONE_O); endproperty
  a_len: assert property (p_len) else $error("bad length");
endmodule
bind samc_top samc_top_assertions u_chk (.CLK_I(CLK_I),
  .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .ADDR_STROBE_I(ADDR_STROBE_I),
  .BANK_EN_I(BANK_EN_I), .CONVERT_TRIGGER_I(CONVERT_TRIGGER_I),
  .DRIVE_EN_I(DRIVE_EN_I), .CHAN_SEL_O(CHAN_SEL_O), .CHAN_O(CHAN_O),
  .CONV_DONE_O(CONV_DONE_O), .DOUT_O(DOUT_O));

// [sim/samc_top_tb_top.sv]
// bench for the converter control block
// assumes comparator model on the analog side, 50 MHz clock
`timescale 1ns/1ps
module samc_top_tb_top;
  import samc_pkg::*;
  logic clk = 0, rst = 1, stb = 0, bank = 1, trig_m = 0, drv = 0, free = 0;
  logic comp, done;
  logic [3:0] addr = 0, chan;
  logic [7:0] lvl = 0, trial;
  logic [7:0] lv [4] = '{8'h00, 8'hFF, 8'hA5, 8'h3C};
  logic [15:0] sel;
  samc_out_s dout;
  int n_fail = 0, check_count = 0;
  // trigger width for a fast clock: 8 clocks plus 2 us at 20 ns
  localparam int TRIG_HOLD = 8 + 100;
  // feedback tie for free running
  wire trig = free ? done : trig_m;
  always #10 clk = ~clk;
  samc_top uut (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
    .ADDR_STROBE_I(stb), .BANK_EN_I(bank), .CONVERT_TRIGGER_I(trig),
    .COMP_I(comp), .DRIVE_EN_I(drv), .CHAN_SEL_O(sel), .CHAN_O(chan),
    .TRIAL_O(trial), .CONV_DONE_O(done), .DOUT_O(dout));
  samc_comp_model cmp (.trial_i(trial), .level_i(lvl), .comp_o(comp));
  // ==========================================
  // shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wdone;
    int i;
    for (i = 0; i < 40 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      n_fail++;
      end_of_test;
    end
  endtask
  task pulse;
    @(posedge clk) trig_m <= 1;
    repeat (TRIG_HOLD) @(posedge clk);
    trig_m <= 0;
  endtask
  // ==========================================
  // scenarios
  task t_addr;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk) addr <= c[3:0];
      stb <= 1;
      @(posedge clk) stb <= 0;
      addr <= ~c[3:0];
      repeat (2) @(posedge clk);
      #1 chk(chan, c);
      chk(sel, 16'h1 << c);
    end
    @(posedge clk) bank <= 0;
    #1 chk(sel, 16'h0);
    @(posedge clk) bank <= 1;
  endtask
  task t_conv(input logic [7:0] v);
    @(posedge clk) lvl <= v;
    drv <= 0;
    pulse;
    wdone;
    chk(dout.data, v);
    chk(dout.oe_n, 8'hFF);
    @(posedge clk) drv <= 1;
    #1 chk(dout.oe_n, 8'h00);
  endtask
  task t_restart;
    @(posedge clk) lvl <= 8'h5A;
    pulse;
    repeat (4) @(posedge clk);
    #1 chk(dout.data, 8'h3C);
    @(posedge clk) lvl <= 8'hC3;
    pulse;
    wdone;
    chk(dout.data, 8'hC3);
  endtask
  task t_free;
    int n;
    logic p;
    n = 0;
    @(posedge clk) lvl <= 8'h81;
    free <= 1;
    for (int i = 0; i < 50; i++) begin
      p = done;
      @(posedge clk);
      #1;
      if (done && !p) n++;
    end
    @(posedge clk) free <= 0;
    #1 chk(n > 1, 1'b1);
    chk(dout.data, 8'h81);
  endtask
  // reset, then run each scenario once, the conversion once for each of the four levels in lv
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_addr;
    for (int k = 0; k < 4; k++) t_conv(lv[k]);
    t_restart;
    t_free;
    end_of_test;
  end
endmodule
